// File: pkg/pmt_defines.svh
`ifndef PMT_DEFINES_SVH
`define PMT_DEFINES_SVH

// Register indices; byte address is four times the index
`define PMT_REG_CONTROL 4'h0
`define PMT_REG_RUN_STATE 4'h1
`define PMT_REG_WEIGHT_P0_FIRST 4'h2
`define PMT_REG_WEIGHT_P0_SECOND 4'h3
`define PMT_REG_WEIGHT_P0_THIRD 4'h4
`define PMT_REG_WEIGHT_P1_FIRST 4'h5
`define PMT_REG_WEIGHT_P1_SECOND 4'h6
`define PMT_REG_WEIGHT_P1_THIRD 4'h7
`define PMT_REG_WEIGHT_P2_FIRST 4'h8
`define PMT_REG_WEIGHT_P2_SECOND 4'h9
`define PMT_REG_WEIGHT_P2_THIRD 4'ha
`define PMT_REG_OFFSET_PLANE_FIRST 4'hb
`define PMT_REG_OFFSET_PLANE_SECOND 4'hc
`define PMT_REG_OFFSET_PLANE_THIRD 4'hd
`define PMT_REG_COUNT 14
`define PMT_WEIGHT_BASE 2
`define PMT_SHADOW_COUNT 12
`define PMT_OFFSET_SLOT 9

// Field positions and reset values
`define PMT_RUN_BIT 0
`define PMT_STATUS_BIT 0
`define PMT_REG_RESET 32'h0000_0000

// Data layout
`define PMT_SAMPLE_W 8
`define PMT_PLANES 3
`define PMT_DATA_W 24
`define PMT_WORD_W 32
`define PMT_ACC_W 45
`define PMT_SAMPLE_MAX 8'hff

// Fixed-point fraction bits, build-time choice 0 to 34
`define PMT_FRAC_BITS 8

// Peer buffering
`define PMT_FIFO_DEPTH 32
`define PMT_FIFO_W 26

`endif

// File: pkg/pmt_pkg.sv
`default_nettype none
`include "pmt_defines.svh"

package pmt_pkg;

    typedef enum logic [1:0] {
        PMT_IDLE = 2'b00,
        PMT_FRAME = 2'b01,
        PMT_STOP = 2'b10
    } pmt_phase_t;

    typedef logic [`PMT_WORD_W-1:0] pmt_word_t;
    typedef logic [`PMT_DATA_W-1:0] pmt_pixel_t;

endpackage

`default_nettype wire

// File: pkg/pmt_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmt_defines.svh"

interface pmt_if;
    logic [`PMT_DATA_W-1:0] din_data;
    logic din_valid;
    logic din_ready;
    logic din_sop;
    logic din_eop;
    logic [`PMT_DATA_W-1:0] dout_data;
    logic dout_valid;
    logic dout_ready;
    logic dout_sop;
    logic dout_eop;

    modport xform (
        input din_data, din_valid, din_sop, din_eop, dout_ready,
        output din_ready, dout_data, dout_valid, dout_sop, dout_eop
    );

    modport peer (
        output din_data, din_valid, din_sop, din_eop, dout_ready,
        input din_ready, dout_data, dout_valid, dout_sop, dout_eop
    );
endinterface

`default_nettype wire

// File: logic/pmt_xform.sv
// Overview of operation
// - Registers update on rising clock edge only.
// - Reset asserts asynchronously, released with clock.
// - Input ready only when a word fits.
// - Source valid exactly when presenting a word.
// - Source marks first and last packet words.
// - Output valid exactly when word is presented.
// - Sink raises ready when able to accept.
// - Output marks first and last packet words.
// - Registers 32 bits, consecutive word addresses.
// - Weights and offsets signed, scaled fixed point.
// - Sample controls at frame start, hold copies.
// - Run bit zero at frame start stops.
// - Status bit zero reports running state.
// - Fraction bits build-time 0 to 34.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_defines.svh"

module pmt_xform
    import pmt_pkg::*;
#(
    parameter int FRAC_BITS = `PMT_FRAC_BITS
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Register port, APB slave
    input wire logic [31:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Video stream
    pmt_if.xform vid
);

    typedef struct packed {
        pmt_phase_t phase;
        pmt_word_t [`PMT_REG_COUNT-1:0] regs;
        pmt_word_t [`PMT_SHADOW_COUNT-1:0] shadow;
        pmt_word_t prdata;
        logic pslverr;
        pmt_pixel_t out_data;
        logic out_valid;
        logic out_sop;
        logic out_eop;
    } pmt_xform_state_t;

    pmt_xform_state_t cur;
    pmt_xform_state_t next_cur;

    // word index decode, byte address is four times it
    function automatic logic reg_hit(input logic [31:0] addr);
        reg_hit = (addr[1:0] == 2'b00) &&
            (addr[31:2] < 30'(`PMT_REG_COUNT));
    endfunction

    function automatic logic [3:0] reg_idx(input logic [31:0] addr);
        reg_idx = addr[5:2];
    endfunction

    logic out_space;
    logic run_req;
    logic sop_waiting;
    logic start_fire;
    logic in_fire;
    pmt_word_t [`PMT_SHADOW_COUNT-1:0] eff;
    pmt_pixel_t result;

    assign run_req = cur.regs[`PMT_REG_CONTROL][`PMT_RUN_BIT];
    // output register frees only when drained
    assign out_space = !cur.out_valid || vid.dout_ready;
    assign sop_waiting = vid.din_valid && vid.din_sop;
    // refuse a frame start while run bit is clear
    assign vid.din_ready = out_space && !(vid.din_sop && !run_req);
    assign in_fire = vid.din_valid && vid.din_ready;
    assign start_fire = in_fire && vid.din_sop;

    // first word of a frame uses the live values
    always_comb begin
        for (int k = 0; k < `PMT_SHADOW_COUNT; k++) begin
            eff[k] = start_fire ? cur.regs[k + `PMT_WEIGHT_BASE]
                : cur.shadow[k];
        end
    end

    genvar p;
    generate
        for (p = 0; p < `PMT_PLANES; p++) begin : g_plane
            logic signed [`PMT_ACC_W-1:0] acc;
            logic signed [`PMT_ACC_W-1:0] scaled;
            always_comb begin
                acc = `PMT_ACC_W'(signed'(eff[`PMT_OFFSET_SLOT + p]));
                for (int j = 0; j < `PMT_PLANES; j++) begin
                    // Widen first so the product cannot wrap at 32 bits
                    acc = acc + `PMT_ACC_W'(signed'(eff[3 * p + j])) *
                        `PMT_ACC_W'(signed'({1'b0,
                        vid.din_data[j * `PMT_SAMPLE_W +: `PMT_SAMPLE_W]}));
                end
                scaled = acc >>> FRAC_BITS;
                if (scaled < 0) begin
                    result[p * `PMT_SAMPLE_W +: `PMT_SAMPLE_W] = 8'h00;
                end else if (scaled > `PMT_ACC_W'(`PMT_SAMPLE_MAX)) begin
                    result[p * `PMT_SAMPLE_W +: `PMT_SAMPLE_W] =
                        `PMT_SAMPLE_MAX;
                end else begin
                    result[p * `PMT_SAMPLE_W +: `PMT_SAMPLE_W] =
                        scaled[`PMT_SAMPLE_W-1:0];
                end
            end
        end
    endgenerate

    always_comb begin
        next_cur = cur;
        next_cur.regs[`PMT_REG_RUN_STATE] = `PMT_REG_RESET;
        next_cur.regs[`PMT_REG_RUN_STATE][`PMT_STATUS_BIT] =
            (cur.phase == PMT_FRAME);

        // Setup phase prepares read data so it comes from a flip-flop
        if (i_psel && !i_penable) begin
            next_cur.pslverr = !reg_hit(i_paddr);
            if (reg_hit(i_paddr)) begin
                next_cur.prdata = cur.regs[reg_idx(i_paddr)];
            end else begin
                next_cur.prdata = `PMT_REG_RESET;
            end
        end
        // Writes land in the access phase; status is read-only
        if (i_psel && i_penable && i_pwrite && reg_hit(i_paddr) &&
            reg_idx(i_paddr) != `PMT_REG_RUN_STATE) begin
            next_cur.regs[reg_idx(i_paddr)] = i_pwdata;
            if (reg_idx(i_paddr) == `PMT_REG_CONTROL) begin
                // Unused control bits stay zero
                next_cur.regs[`PMT_REG_CONTROL] = `PMT_REG_RESET;
                next_cur.regs[`PMT_REG_CONTROL][`PMT_RUN_BIT] =
                    i_pwdata[`PMT_RUN_BIT];
            end
        end

        case (cur.phase)
            PMT_IDLE, PMT_FRAME: begin
                // stop when a frame start finds run clear
                if (sop_waiting && !run_req && out_space) begin
                    next_cur.phase = PMT_STOP;
                end else if (start_fire) begin
                    next_cur.phase = PMT_FRAME;
                end
            end
            PMT_STOP: begin
                // restart on the next accepted frame start
                if (start_fire) begin
                    next_cur.phase = PMT_FRAME;
                end
            end
            default: begin
                next_cur.phase = PMT_IDLE;
            end
        endcase

        // hold copies for the rest of the frame
        if (start_fire) begin
            for (int k = 0; k < `PMT_SHADOW_COUNT; k++) begin
                next_cur.shadow[k] = cur.regs[k + `PMT_WEIGHT_BASE];
            end
        end

        // valid set with data, cleared once taken
        if (in_fire) begin
            next_cur.out_data = result;
            next_cur.out_valid = 1'b1;
            // packet markers travel with the word
            next_cur.out_sop = vid.din_sop;
            next_cur.out_eop = vid.din_eop;
        end else if (vid.dout_ready) begin
            next_cur.out_valid = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_prdata = cur.prdata;
    assign o_pslverr = cur.pslverr && i_psel && i_penable;
    assign o_pready = i_psel && i_penable;
    assign vid.dout_data = cur.out_data;
    assign vid.dout_valid = cur.out_valid;
    assign vid.dout_sop = cur.out_sop;
    assign vid.dout_eop = cur.out_eop;

endmodule // pmt_xform

`default_nettype wire

// File: logic/pmt_peer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmt_defines.svh"

module pmt_fifo
    import pmt_pkg::*;
#(
    parameter int WIDTH = `PMT_FIFO_W,
    parameter int DEPTH = `PMT_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Fill side
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    // Drain side
    output logic [WIDTH-1:0] o_rd_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } pmt_fifo_state_t;

    pmt_fifo_state_t cur;
    pmt_fifo_state_t next_cur;
    logic push;
    logic pop;

    assign o_wr_ready = (cur.count != (AW + 1)'(DEPTH));
    assign o_rd_valid = (cur.count != '0);
    assign push = i_wr_valid && o_wr_ready;
    assign pop = o_rd_valid && i_rd_ready;
    assign o_rd_data = cur.mem[cur.rd_ptr];

    always_comb begin
        next_cur = cur;
        if (push) begin
            next_cur.mem[cur.wr_ptr] = i_wr_data;
            next_cur.wr_ptr = (cur.wr_ptr == AW'(DEPTH - 1)) ? '0
                : cur.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_cur.rd_ptr = (cur.rd_ptr == AW'(DEPTH - 1)) ? '0
                : cur.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_cur.count = cur.count + 1'b1;
        end else if (pop && !push) begin
            next_cur.count = cur.count - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

endmodule // pmt_fifo

module pmt_peer
    import pmt_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Source user side
    input wire logic [`PMT_DATA_W-1:0] i_src_data,
    input wire logic i_src_sop,
    input wire logic i_src_eop,
    input wire logic i_src_valid,
    output logic o_src_ready,
    // Sink user side
    output logic [`PMT_DATA_W-1:0] o_snk_data,
    output logic o_snk_sop,
    output logic o_snk_eop,
    output logic o_snk_valid,
    input wire logic i_snk_ready,
    // Video stream
    pmt_if.peer vid
);

    typedef struct packed {
        pmt_pixel_t data;
        logic sop;
        logic eop;
        logic valid;
    } pmt_peer_state_t;

    pmt_peer_state_t cur;
    pmt_peer_state_t next_cur;
    logic [`PMT_FIFO_W-1:0] fifo_out;
    logic fifo_valid;

    // markers are buffered alongside each word
    pmt_fifo #(
        .WIDTH(`PMT_FIFO_W),
        .DEPTH(`PMT_FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_wr_data({i_src_sop, i_src_eop, i_src_data}),
        .i_wr_valid(i_src_valid),
        .o_wr_ready(o_src_ready),
        .o_rd_data(fifo_out),
        .o_rd_valid(fifo_valid),
        .i_rd_ready(vid.din_ready)
    );

    // valid only while a buffered word is shown
    assign vid.din_valid = fifo_valid;
    assign vid.din_data = fifo_out[`PMT_DATA_W-1:0];
    assign vid.din_sop = fifo_out[`PMT_DATA_W + 1] && fifo_valid;
    assign vid.din_eop = fifo_out[`PMT_DATA_W] && fifo_valid;

    // ready whenever the capture stage can take a word
    assign vid.dout_ready = !cur.valid || i_snk_ready;

    always_comb begin
        next_cur = cur;
        if (vid.dout_valid && vid.dout_ready) begin
            next_cur.data = vid.dout_data;
            next_cur.sop = vid.dout_sop;
            next_cur.eop = vid.dout_eop;
            next_cur.valid = 1'b1;
        end else if (i_snk_ready) begin
            next_cur.valid = 1'b0;
        end
    end

    // same asynchronous assertion as the device end
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_snk_data = cur.data;
    assign o_snk_sop = cur.sop;
    assign o_snk_eop = cur.eop;
    assign o_snk_valid = cur.valid;

endmodule // pmt_peer

`default_nettype wire

// File: testbench/pmt_props.sv
`timescale 1ns/1ps
`default_nettype none

module pmt_props (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Stream
    input wire logic din_valid,
    input wire logic din_ready,
    input wire logic din_sop,
    input wire logic din_eop,
    input wire logic [23:0] dout_data,
    input wire logic dout_valid,
    input wire logic dout_ready,
    input wire logic dout_sop,
    input wire logic dout_eop
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    sequence take_s;
        din_valid && din_ready;
    endsequence
    sequence stall_s;
        dout_valid && !dout_ready;
    endsequence

    stall_hold_a: assert property (stall_s |=> dout_valid &&
        $stable(dout_data) && $stable({dout_sop, dout_eop}))
        else $error("stalled output changed");
    take_show_a: assert property (take_s |=> dout_valid)
        else $error("accepted word not shown");
    marks_pass_a: assert property (take_s |=>
        dout_sop == $past(din_sop) && dout_eop == $past(din_eop))
        else $error("packet marks lost");
    full_block_a: assert property (stall_s |-> !din_ready)
        else $error("ready while output full");
    full_rate_a: assert property (din_valid && !din_sop &&
        !(dout_valid && !dout_ready) |-> din_ready)
        else $error("ready withheld");
    no_source_a: assert property (!(din_valid && din_ready) &&
        !(dout_valid && !dout_ready) |=> !dout_valid)
        else $error("output without input");
    rise_cause_a: assert property ($rose(dout_valid) |->
        $past(din_valid) && $past(din_ready))
        else $error("valid rose without cause");
    reset_clear_a: assert property (disable iff (1'b0)
        i_reset |=> !dout_valid)
        else $error("valid during reset");
endmodule // pmt_props

`default_nettype wire

// File: testbench/test_pixel_matrix_transform.sv
`timescale 1ns/1ps
`default_nettype none

module test_pixel_matrix_transform;
    import pmt_pkg::*;
    localparam int FB = 8;
    logic i_ref_clk = 0;
    logic i_reset = 1;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [23:0] s_data = 0, k_data;
    logic s_sop = 0, s_eop = 0, s_valid = 0, s_rdy;
    logic k_sop, k_eop, k_valid, k_rdy = 0;
    logic [31:0] seed = 32'h3948;
    int miscompares = 0, checks = 0, stall = 0;
    int regs [14], act [14];
    logic [25:0] expq [$];
    pmt_if vif ();

    always #25 i_ref_clk = ~i_ref_clk;

    pmt_xform #(.FRAC_BITS(FB)) u_pmt_xform (.i_ref_clk, .i_reset,
        .i_paddr(paddr), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .vid(vif.xform));
    pmt_peer u_pmt_peer (.i_ref_clk, .i_reset, .i_src_data(s_data),
        .i_src_sop(s_sop), .i_src_eop(s_eop), .i_src_valid(s_valid),
        .o_src_ready(s_rdy), .o_snk_data(k_data), .o_snk_sop(k_sop),
        .o_snk_eop(k_eop), .o_snk_valid(k_valid), .i_snk_ready(k_rdy),
        .vid(vif.peer));
    pmt_props u_pmt_props (.i_ref_clk, .i_reset,
        .din_valid(vif.din_valid), .din_ready(vif.din_ready),
        .din_sop(vif.din_sop), .din_eop(vif.din_eop),
        .dout_data(vif.dout_data), .dout_valid(vif.dout_valid),
        .dout_ready(vif.dout_ready), .dout_sop(vif.dout_sop),
        .dout_eop(vif.dout_eop));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Small signed values so results land both inside and outside 0..255
    function automatic logic [31:0] rw(input int i);
        return $signed(rnd()) >>> (i > 10 ? 16 : 24);
    endfunction

    function automatic logic [23:0] xf(input logic [23:0] px);
        logic [23:0] r;
        longint a;
        for (int p = 0; p < 3; p++) begin
            a = act[11 + p];
            for (int j = 0; j < 3; j++)
                a += longint'(act[2 + 3 * p + j]) * px[8 * j +: 8];
            a = a >>> FB;
            r[8 * p +: 8] = a < 0 ? 8'h00 : a > 255 ? 8'hff : a[7:0];
        end
        return r;
    endfunction

    task automatic chk(input logic [31:0] got, exp, input string m);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s %h not %h", $time, m, got, exp);
        end
    endtask

    task automatic hang(input string m);
        miscompares++;
        $display("wrong value at %0t: %s timed out", $time, m);
        print_verdict();
    endtask

    task automatic apb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] rd, output logic er);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_ref_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (!pready && n < 50);
        if (n == 50) hang("apb");
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge i_ref_clk);
    endtask

    task automatic wr(input int i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1, i * 4, d, r, e);
        if (i > 1) regs[i] = d;
        else if (i == 0) regs[0] = d & 1;
    endtask

    task automatic rdc(input int i, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(0, i * 4, 0, r, e);
        chk(r, x, "read data");
        chk(e, xe, "error flag");
    endtask

    task automatic note(input logic [23:0] d, input logic s, e);
        if (s) act = regs;
        expq.push_back({s, e, xf(d)});
    endtask

    task automatic push(input logic [23:0] d, input logic s, e);
        int n;
        s_data <= d;
        s_sop <= s;
        s_eop <= e;
        s_valid <= 1;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (!s_rdy && n < 400);
        if (n == 400) hang("push");
        note(d, s, e);
    endtask

    task automatic drain();
        for (int n = 0; n < 600 && expq.size() > 0; n++)
            @(posedge i_ref_clk);
        if (expq.size() > 0) hang("drain");
    endtask

    task automatic done(input string m);
        $display("test %s done", m);
    endtask

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Sink user side, compares each word taken out
    always @(posedge i_ref_clk) begin
        if (k_valid && k_rdy) begin
            if (expq.size() == 0) chk(1, 0, "extra word");
            else chk({k_sop, k_eop, k_data}, expq.pop_front(), "pixel");
        end
        k_rdy <= stall == 1 ? 1'(rnd()) : stall == 0;
    end

    initial begin
        logic [31:0] r;
        logic e;
        int n;
        repeat (6) @(posedge i_ref_clk);
        i_reset <= 0;
        @(posedge i_ref_clk);
        for (int i = 0; i < 15; i++) rdc(i, 0, i == 14);
        apb(0, 32'h9, 0, r, e);
        chk(e, 1, "misaligned");
        for (int i = 2; i < 14; i++) wr(i, rw(i));
        wr(0, 32'hffffffff);
        wr(1, 32'hffffffff);
        for (int i = 0; i < 14; i++) rdc(i, regs[i], 0);
        done("registers");
        stall = 1;
        for (int k = 0; k < 4; k++) push(24'(rnd()), k == 0, 0);
        s_valid <= 0;
        drain();
        rdc(1, 1, 0);
        // Mid-frame writes must not reach the words still to come
        for (int i = 2; i < 14; i++) wr(i, rw(i));
        for (int k = 0; k < 4; k++) push(24'(rnd()), 0, k == 3);
        s_valid <= 0;
        drain();
        done("frame");
        stall = 2;
        n = 0;
        for (int k = 0; k < 40; k++) begin
            s_data <= 24'(rnd());
            s_sop <= k == 0;
            s_eop <= 0;
            s_valid <= 1;
            @(posedge i_ref_clk);
            if (s_rdy) begin
                note(s_data, s_sop, 0);
                n++;
            end
        end
        s_valid <= 0;
        chk(n, 34, "fill depth");
        stall = 1;
        drain();
        done("backpressure");
        wr(0, 0);
        push(24'(rnd()), 1, 1);
        s_valid <= 0;
        repeat (20) @(posedge i_ref_clk);
        chk(expq.size(), 1, "held word");
        rdc(1, 0, 0);
        wr(0, 1);
        drain();
        rdc(1, 1, 0);
        done("stop");
        // Reset in mid-frame must clear without waiting for a clock edge
        stall = 2;
        for (int k = 0; k < 3; k++) push(24'(rnd()), k == 0, 0);
        s_valid <= 0;
        repeat (4) @(posedge i_ref_clk);
        i_reset <= 1;
        @(negedge i_ref_clk);
        chk({vif.dout_valid, vif.din_valid, k_valid}, 0, "async clear");
        expq.delete();
        repeat (2) @(posedge i_ref_clk);
        i_reset <= 0;
        @(posedge i_ref_clk);
        rdc(0, 0, 0);
        rdc(1, 0, 0);
        done("reset");
        print_verdict();
    end
endmodule // test_pixel_matrix_transform

`default_nettype wire
